// >>> pf_pkg.sv
// constants, types and helpers shared by the data prefetch block
// assumes byte addresses, 64-byte lines and 4-KByte pages
`default_nettype none
package pf_pkg;
	// ----------------------------------------------------------------
	// address geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W        = 32;            // byte address width
	localparam int LINE_OFS      = 6;             // 64-byte cache line
	localparam int PAGE_OFS      = 12;            // 4-KByte page
	localparam int LINE_W        = ADDR_W - LINE_OFS;   // line address width
	localparam int DW            = LINE_W + 1;          // signed line distance
	localparam int PAGE_LINE_BIT = PAGE_OFS - LINE_OFS; // page field in line addr
	// ----------------------------------------------------------------
	// stream detector defaults
	// ----------------------------------------------------------------
	localparam int AHEAD_LINES   = 2;             // steps kept ahead of stream
	localparam int TRIGGER_BYTES = 256;           // trigger threshold distance
	localparam int TRAIN_MISSES  = 2;             // small-distance misses to arm
	localparam int HITS_W        = 4;             // training counter width
	localparam int DROP_L1_HIT   = 0;             // 1: drop, 0: wait on l1 hit
	// ----------------------------------------------------------------
	// software prefetch variants and target levels
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		KIND_NTA = 2'h0,
		KIND_T0  = 2'h1,
		KIND_T1  = 2'h2,
		KIND_T2  = 2'h3
	} kind_t;
	typedef enum logic [1:0] {
		LVL_L1  = 2'h0,
		LVL_L2  = 2'h1,
		LVL_LLC = 2'h2,
		LVL_NTA = 2'h3
	} lvl_t;
	typedef enum logic {
		ISS_IDLE = 1'b0,
		ISS_BUSY = 1'b1
	} iss_t;

	// target level of a software variant
	function automatic lvl_t kindLevel(input kind_t k);
		case (k)
			KIND_NTA: kindLevel = LVL_NTA;
			KIND_T0:  kindLevel = LVL_L1;
			KIND_T1:  kindLevel = LVL_L2;
			default:  kindLevel = LVL_LLC;
		endcase
	endfunction

	// magnitude of a signed line distance
	function automatic logic [DW-1:0] absLines(input logic signed [DW-1:0] d);
		absLines = d[DW-1] ? DW'(-d) : DW'(d);
	endfunction
endpackage
`default_nettype wire

// >>> cand_link_if.sv
// candidate hand-off from the stream tracker to the issue logic
// assumes both ends run on clk_sys
`timescale 1ns/1ps
`default_nettype none
interface cand_link_if;
	import pf_pkg::*;
	logic              valid;   // candidate line waiting
	logic              ready;   // issue logic takes it
	logic [LINE_W-1:0] line;    // line address to fetch
	modport src (output valid, output line, input ready);
	modport dst (input valid, input line, output ready);
endinterface
`default_nettype wire

// >>> stream_tracker.sv
// miss stream detector: trains on demand misses, offers fetch lines
// assumes one miss report per cycle at most, on clk_sys
`timescale 1ns/1ps
`default_nettype none
module stream_tracker
#(
	parameter int TRIGGER = pf_pkg::TRIGGER_BYTES,
	parameter int TRAIN   = pf_pkg::TRAIN_MISSES
)
(
	input  wire logic                      clk_sys,
	input  wire logic                      reset_n,
	input  wire logic                      missValid,
	input  wire logic [pf_pkg::LINE_W-1:0] missLine,
	cand_link_if.src                       cand
);
	import pf_pkg::*;
	localparam int TRIG_LINES = TRIGGER >> LINE_OFS; // threshold in lines

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [LINE_W-1:0]    lastLine_r;   // previous miss line
	logic                 haveLast_r;   // lastLine_r holds a miss
	logic signed [DW-1:0] stride_r;     // last seen distance
	logic [HITS_W-1:0]    hits_r;       // consecutive small distances
	logic                 valid_r;      // candidate pending
	logic [LINE_W-1:0]    line_r;       // candidate line
	logic signed [DW-1:0] stepHold_r;   // step used for candidate (checks)

	// ----------------------------------------------------------------
	// distance and step
	// ----------------------------------------------------------------
	logic signed [DW-1:0] delta;
	logic [DW-1:0]        absD;
	logic                 smallDist;
	logic                 trained;
	logic signed [DW-1:0] step;
	logic [LINE_W-1:0]    tgt;
	logic                 samePage;
	logic                 loadNow;

	always_comb
	begin
		delta     = $signed({1'b0, missLine}) - $signed({1'b0, lastLine_r});
		absD      = absLines(delta);
		// distance compared in whole lines against the byte threshold
		smallDist = haveLast_r && (delta != '0) && (absD < DW'(TRIG_LINES)); // R04 R11
		trained   = smallDist && (hits_r >= HITS_W'(TRAIN - 1)); // R03
		// constant stride is followed only below half the threshold,
		// otherwise the stream falls back to the next line
		if ((hits_r != '0) && (delta == stride_r) && ((absD << 1) < DW'(TRIG_LINES)))
			step = delta; // R05
		else
			step = delta[DW-1] ? -DW'(1) : DW'(1);
		// no end-of-array knowledge: fetches run past the last element
		tgt      = LINE_W'($signed({1'b0, missLine}) + step * AHEAD_LINES); // R01 R06
		samePage = tgt[LINE_W-1:PAGE_LINE_BIT] == missLine[LINE_W-1:PAGE_LINE_BIT]; // R02
		loadNow  = missValid && trained && samePage && (!valid_r || cand.ready);
	end

	// ----------------------------------------------------------------
	// training history
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lastLine_r <= '0;
			haveLast_r <= 1'b0;
			stride_r   <= '0;
			hits_r     <= '0;
		end
		else if (missValid)
		begin
			lastLine_r <= missLine;
			haveLast_r <= 1'b1;
			stride_r   <= delta;
			// large jumps restart the start-up penalty
			if (!smallDist)
				hits_r <= '0;
			else if (hits_r != '1)
				hits_r <= hits_r + HITS_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// candidate slot; a busy slot drops the newer hint, it is only a hint
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			valid_r    <= 1'b0;
			line_r     <= '0;
			stepHold_r <= '0;
		end
		else if (loadNow)
		begin
			valid_r    <= 1'b1;
			line_r     <= tgt;
			stepHold_r <= step;
		end
		else if (cand.ready)
			valid_r <= 1'b0;
	end

	assign cand.valid = valid_r;
	assign cand.line  = line_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	AST_NO_PAGE_CROSS: assert property ($rose(valid_r) |-> // R02
		line_r[LINE_W-1:PAGE_LINE_BIT] == lastLine_r[LINE_W-1:PAGE_LINE_BIT])
		else $error("prefetch candidate left the demand page");
	AST_TWO_AHEAD: assert property ($rose(valid_r) |-> // R01
		line_r == LINE_W'($signed({1'b0, lastLine_r}) + stepHold_r * AHEAD_LINES))
		else $error("candidate not two steps ahead of the miss");
	AST_STARTUP: assert property ($rose(valid_r) |-> // R03
		$past(hits_r) >= HITS_W'(TRAIN - 1))
		else $error("prefetch issued before training finished");
	AST_LARGE_RESET: assert property (missValid && haveLast_r && !smallDist |=> // R04
		hits_r == '0 ##1 !$rose(valid_r))
		else $error("large distance did not restart training");
	AST_HALF_STRIDE: assert property ($rose(valid_r) && (absLines(stepHold_r) > DW'(1)) |-> // R05
		(absLines(stepHold_r) << 1) < DW'(TRIG_LINES))
		else $error("stride at or above half threshold was followed");
	// elaboration check: training counter is four bits, threshold whole lines
	if (TRAIN < 2 || TRAIN > 15 || TRIGGER < 128 || (TRIGGER % 64) != 0)
	begin : gBadParams
		$error("stream_tracker: unsupported parameters");
	end
endmodule // stream_tracker
`default_nettype wire

// >>> stride_data_prefetcher.sv
// data prefetch block: automatic stride streams plus software hints
// assumes inputs synchronous to clk_sys; one fetch accepted per handshake
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R01] fill last-level cache two steps ahead
// [R02] never fetch across a 4-KByte page
// [R03] stay idle until several misses seen
// [R04] trigger on small distance between successive misses
// [R05] constant stride used only below half threshold
// [R06] keep fetching past the array end
// [R07] four software hint variants pick target level
// [R08] l1-hit hint waits on traffic or drops
// [R09] prefetch traffic decoupled from execution
// [R10] software must not prefetch instruction code
// [R11] threshold is a byte parameter on line distance
module stride_data_prefetcher
#(
	parameter int TRIGGER_BYTES = pf_pkg::TRIGGER_BYTES,
	parameter int TRAIN_MISSES  = pf_pkg::TRAIN_MISSES,
	parameter int DROP_L1_HIT   = pf_pkg::DROP_L1_HIT
)
(
	input  wire logic                      clk_sys,
	input  wire logic                      reset_n,
	input  wire logic                      missValid,    // demand data miss
	input  wire logic [pf_pkg::ADDR_W-1:0] missAddr,
	input  wire logic                      swValid,      // software hint request
	output logic                           swReady,
	input  wire logic [pf_pkg::ADDR_W-1:0] swAddr,
	input  wire pf_pkg::kind_t             swKind,
	input  wire logic                      swL1Hit,      // line already in l1
	input  wire logic                      memPending,   // memory accesses outstanding
	output logic                           fetchValid,   // line fetch to the cache side
	input  wire logic                      fetchReady,
	output logic [pf_pkg::ADDR_W-1:0]      fetchAddr,
	output pf_pkg::lvl_t                   fetchLevel,
	output logic                           fetchSoftware,
	output logic                           swDropped     // hint discarded pulse
);
	import pf_pkg::*;

	// ----------------------------------------------------------------
	// stream tracker
	// ----------------------------------------------------------------
	cand_link_if candLink ();                // tracker to issue hand-off

	stream_tracker #(
		.TRIGGER (TRIGGER_BYTES),
		.TRAIN   (TRAIN_MISSES)
	) tracker (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.missValid (missValid),
		.missLine  (missAddr[ADDR_W-1:LINE_OFS]),
		.cand      (candLink.src)
	);

	// ----------------------------------------------------------------
	// software hint slot
	// ----------------------------------------------------------------
	logic              swPend_r;     // hint waiting for issue
	logic [LINE_W-1:0] swLine_r;     // hinted line
	lvl_t              swLvl_r;      // its target level
	logic              swHit_r;      // hinted line was in l1
	logic              swDropped_r;  // drop pulse
	logic              swTake;       // hint accepted this cycle
	logic              swDrop;       // accepted hint is discarded
	logic              swGo;         // slot may issue now

	// execution never waits for memory; only a full slot back-pressures
	assign swReady = !swPend_r; // R09
	assign swTake  = swValid && swReady;
	assign swDrop  = swTake && swL1Hit && (DROP_L1_HIT != 0); // R08
	// an l1 hit waits until earlier memory traffic has drained
	assign swGo    = swPend_r && (!swHit_r || !memPending); // R08

	iss_t state_r;
	iss_t state_nxt;

	// slot fill and release
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			swPend_r <= 1'b0;
			swLine_r <= '0;
			swLvl_r  <= LVL_L1;
			swHit_r  <= 1'b0;
		end
		else if (swTake && !swDrop)
		begin
			swPend_r <= 1'b1;
			swLine_r <= swAddr[ADDR_W-1:LINE_OFS];
			swLvl_r  <= kindLevel(swKind); // R07
			swHit_r  <= swL1Hit;
		end
		else if (state_r == ISS_IDLE && swGo)
			swPend_r <= 1'b0;
	end

	// drop indication, one cycle
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			swDropped_r <= 1'b0;
		else
			swDropped_r <= swDrop;
	end

	// ----------------------------------------------------------------
	// issue state machine
	// ----------------------------------------------------------------
	// hardware candidates only when no hint can go; hints are explicit
	assign candLink.ready = (state_r == ISS_IDLE) && !swGo;

	always_comb
	begin
		case (state_r)
			ISS_IDLE: state_nxt = (swGo || candLink.valid) ? ISS_BUSY : ISS_IDLE;
			ISS_BUSY: state_nxt = fetchReady ? ISS_IDLE : ISS_BUSY;
			default:  state_nxt = ISS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			state_r <= ISS_IDLE;
		else
			state_r <= state_nxt;
	end

	// ----------------------------------------------------------------
	// fetch request registers
	// ----------------------------------------------------------------
	logic              fetchValid_r;
	logic [LINE_W-1:0] fetchLine_r;
	lvl_t              fetchLevel_r;
	logic              fetchSw_r;
	logic              fetchHit_r;   // issued hint had hit l1 (checks)

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fetchValid_r <= 1'b0;
			fetchLine_r  <= '0;
			fetchLevel_r <= LVL_LLC;
			fetchSw_r    <= 1'b0;
			fetchHit_r   <= 1'b0;
		end
		else if (state_r == ISS_IDLE && swGo)
		begin
			fetchValid_r <= 1'b1;
			fetchLine_r  <= swLine_r;
			fetchLevel_r <= swLvl_r; // R07
			fetchSw_r    <= 1'b1;
			fetchHit_r   <= swHit_r;
		end
		else if (state_r == ISS_IDLE && candLink.valid)
		begin
			// automatic fetches always fill the last-level cache
			fetchValid_r <= 1'b1;
			fetchLine_r  <= candLink.line;
			fetchLevel_r <= LVL_LLC; // R01
			fetchSw_r    <= 1'b0;
			fetchHit_r   <= 1'b0;
		end
		else if (fetchReady)
			fetchValid_r <= 1'b0;
	end

	assign fetchValid    = fetchValid_r;
	assign fetchAddr     = {fetchLine_r, LINE_OFS'(0)};
	assign fetchLevel    = fetchLevel_r;
	assign fetchSoftware = fetchSw_r;
	assign swDropped     = swDropped_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence sStalled;
		fetchValid && !fetchReady;
	endsequence
	sequence sHeld;
		fetchValid && $stable(fetchAddr) && $stable(fetchLevel);
	endsequence

	AST_FETCH_HOLD: assert property (sStalled |=> sHeld) // R09
		else $error("fetch request changed while stalled");
	AST_HW_LEVEL: assert property (fetchValid && !fetchSoftware |-> fetchLevel == LVL_LLC) // R01
		else $error("automatic fetch not aimed at last-level cache");
	AST_SW_LEVEL: assert property (swTake && !swDrop |=> swLvl_r == kindLevel($past(swKind))) // R07
		else $error("hint variant mapped to wrong level");
	AST_HIT_WAITS: assert property ($rose(fetchValid) && fetchSoftware && fetchHit_r |-> // R08
		!$past(memPending))
		else $error("l1-hit hint issued over outstanding traffic");
	AST_HIT_DROP: assert property (swTake && swL1Hit && (DROP_L1_HIT != 0) |=> // R08
		swDropped && !swPend_r)
		else $error("l1-hit hint not dropped");
	// a waiting automatic candidate would take the port first
	AST_SW_ISSUE: assert property (swTake && !swL1Hit && !swPend_r && !fetchValid && // R09
		!candLink.valid |=> ##1 fetchValid && fetchSoftware)
		else $error("free hint not issued in two cycles");

	// an accepted fetch leaves the port empty for one cycle
	sequence sTaken;
		fetchValid && fetchReady;
	endsequence
	AST_PORT_GAP: assert property (sTaken |=> !fetchValid) // R09
		else $error("fetch port reissued in the accept cycle");

	// elaboration check: only wait (0) and drop (1) behaviours exist
	// refused at build time rather than silently acting as one of them
	if (DROP_L1_HIT < 0 || DROP_L1_HIT > 1)
	begin : gBadDrop
		$error("stride_data_prefetcher: DROP_L1_HIT must be 0 or 1");
	end
endmodule // stride_data_prefetcher
`default_nettype wire

// >>> llc_model.sv
// cache-side partner: takes line fetches, promptly or with stalls
// assumes the block holds each fetch until it sees fetchReady
`timescale 1ns/1ps
`default_nettype none
module llc_model
(
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic slowMode,   // stall fetches a few cycles
	output logic      fetchReady
);
	// ------------------------------------------------------------
	// acceptance pacing
	// ------------------------------------------------------------
	logic [1:0] waitCnt;   // stall phase counter
	// slow mode takes one cycle in four, so a held request must wait
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			waitCnt    <= 2'h0;
			fetchReady <= 1'b0;
		end
		else
		begin
			waitCnt    <= #1 waitCnt + 2'h1;
			fetchReady <= #1 !slowMode || (waitCnt == 2'h2);
		end
	end
endmodule // llc_model
`default_nettype wire

// >>> tb.sv
// self-checking bench for the data prefetch block
// assumes pf_pkg, the block and llc_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pf_pkg::*;
	// ------------------------------------------------------------
	// signals and bench state
	// ------------------------------------------------------------
	localparam int TRIG  = 384;     // non-default threshold in bytes
	localparam int TRAIN = 3;       // misses before arming
	logic              clk_sys, reset_n, missValid, swValid;
	logic              swReady, swL1Hit, memPending, slowMode;
	logic              fetchValid, fetchReady, fetchSoftware, swDropped;
	logic [ADDR_W-1:0] missAddr, swAddr, fetchAddr;
	kind_t             swKind;
	lvl_t              fetchLevel;
	logic [34:0]       gotQ[$], expQ[$];  // {software, level, addr}
	int                seed = 32'h1b697bf9;
	int                miscompares = 0, cmp_count = 0;
	logic              dropDropped;   // drop pulse of the drop-mode copy
	int                dropSeen = 0;  // drop pulses counted
	int                prevLine, prevD, hits, hasPrev;  // predictor history
	int                strideTab [9] = '{1, -1, 2, -2, 3, -3, 5, 8, 0};

	stride_data_prefetcher #(.TRIGGER_BYTES(TRIG), .TRAIN_MISSES(TRAIN)) DUT (
		.clk_sys(clk_sys), .reset_n(reset_n), .missValid(missValid),
		.missAddr(missAddr), .swValid(swValid), .swReady(swReady),
		.swAddr(swAddr), .swKind(swKind), .swL1Hit(swL1Hit),
		.memPending(memPending), .fetchValid(fetchValid),
		.fetchReady(fetchReady), .fetchAddr(fetchAddr),
		.fetchLevel(fetchLevel), .fetchSoftware(fetchSoftware),
		.swDropped(swDropped));
	// same stimulus, drop mode: only the l1-hit hint tells the two apart
	stride_data_prefetcher #(.TRIGGER_BYTES(TRIG), .TRAIN_MISSES(TRAIN),
		.DROP_L1_HIT(1)) dropDut (
		.clk_sys(clk_sys), .reset_n(reset_n), .missValid(missValid),
		.missAddr(missAddr), .swValid(swValid), .swReady(),
		.swAddr(swAddr), .swKind(swKind), .swL1Hit(swL1Hit),
		.memPending(memPending), .fetchValid(), .fetchReady(fetchReady),
		.fetchAddr(), .fetchLevel(), .fetchSoftware(),
		.swDropped(dropDropped));
	llc_model partner (.clk_sys(clk_sys), .reset_n(reset_n),
		.slowMode(slowMode), .fetchReady(fetchReady));

	// ------------------------------------------------------------
	// clock, monitor and watchdog
	// ------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = !clk_sys;
	end
	// log every accepted fetch; design outputs still hold pre-edge values
	always @(posedge clk_sys)
		if (reset_n === 1'b1 && fetchValid === 1'b1 && fetchReady === 1'b1)
			gotQ.push_back({fetchSoftware, fetchLevel, fetchAddr});
	// drop pulses of the drop-mode copy; one expected in the whole run
	always @(posedge clk_sys)
		if (reset_n === 1'b1 && dropDropped === 1'b1)
			dropSeen++;
	// runs far past the expected run of under 1600 cycles
	initial
	begin
		#(100 * 20000);
		miscompares++;
		stop_test();
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// target level expected for a hint variant
	function automatic logic [1:0] expLevel(input int k);
		expLevel = (k == 0) ? 2'h3 : 2'(k - 1);
	endfunction
	// inputs always move one ns after the edge
	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask
	task automatic doReset();
		reset_n = 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		hits    = 0;
		hasPrev = 0;
	endtask
	// expected automatic fetch for one miss, from the stream rules
	task automatic predict(input int line);
		int d, ad, st, tgt;
		d  = line - prevLine;
		ad = (d < 0) ? -d : d;
		if (hasPrev != 0 && ad != 0 && ad * 64 < TRIG)
		begin
			st  = (d == prevD && 2 * ad < TRIG / 64) ? d : ((d < 0) ? -1 : 1);
			tgt = (line + 2 * st) & 32'h03ffffff;
			if (hits >= TRAIN - 1 && (tgt >> 6) == (line >> 6))
				expQ.push_back({3'h2, 32'(tgt) << 6});
			hits = (hits < 15) ? hits + 1 : 15;
		end
		else
			hits = 0;
		prevD    = d;
		prevLine = line;
		hasPrev  = 1;
	endtask
	// spacing keeps the tracker slot empty before the next miss
	task automatic miss(input int line);
		missValid = 1'b1;
		missAddr  = {26'(line), 6'($random(seed))};
		predict(line);
		step();
		missValid = 1'b0;
		repeat (7) step();
	endtask
	// hint held until the edge at which swReady is high
	task automatic hint(input logic [31:0] a, input int k, input logic hit);
		int n;
		swValid = 1'b1;
		swAddr  = a;
		swKind  = kind_t'(k);
		swL1Hit = hit;
		n = 0;
		while (swReady !== 1'b1 && n < 50)
		begin
			step();
			n++;
		end
		step();
		swValid = 1'b0;
		expQ.push_back({1'b1, expLevel(k), a & 32'hffffffc0});
		// let an edge pass so the next call never re-raises swValid at once
		step();
	endtask
	task automatic drain();
		logic [34:0] g, e;
		repeat (12) step();
		check(32'(gotQ.size()), 32'(expQ.size()));
		while (expQ.size() > 0 && gotQ.size() > 0)
		begin
			g = gotQ.pop_front();
			e = expQ.pop_front();
			check(g[31:0], e[31:0]);
			check(32'(g[34:32]), 32'(e[34:32]));
		end
		gotQ.delete();
		expQ.delete();
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		int s, k, n, line, stride;
		{missValid, swValid, swL1Hit, memPending, slowMode} = 5'h0;
		{missAddr, swAddr} = 64'h0;
		swKind = KIND_NTA;
		doReset();
		check(32'({swReady, fetchValid, fetchSoftware, swDropped, fetchLevel}), 32'h22);
		// stream 0 runs off its page end; every third stream is irregular
		for (s = 0; s < 25; s++)
		begin
			line   = $random(seed) & 32'h03ffffff;
			stride = strideTab[$unsigned($random(seed)) % 9];
			if (s == 0)
			begin
				line   = (line & 32'h03ffffc0) | 32'h3a;
				stride = 1;
			end
			if (s == 12)
			begin
				doReset();
				check(32'({swReady, fetchValid, fetchSoftware, swDropped, fetchLevel}), 32'h22);
			end
			for (n = 0; n < 6; n++)
			begin
				if (s % 3 == 2)
					stride = strideTab[$unsigned($random(seed)) % 9];
				miss(line);
				line = line + stride;
			end
			drain();
		end
		// back-to-back hints of every variant against a stalling cache side
		slowMode = 1'b1;
		for (k = 0; k < 4; k++)
			hint($random(seed), k, 1'b0);
		drain();
		// l1-hit hint in wait mode: held while memory traffic is pending
		memPending = 1'b1;
		hint(32'h00123440, 1, 1'b1);
		for (n = 0; n < 10; n++)
		begin
			step();
			check(32'(fetchValid | swDropped), 32'h0);
		end
		memPending = 1'b0;
		drain();
		check(32'(dropSeen), 32'h1);
		stop_test();
	end
endmodule // tb
`default_nettype wire
